// ### acs_serial_port.sv
// configuration serial slave port: three/four-wire, header decode, burst addressing
`timescale 1ns/10ps

// Function
// - no lowest serial clock rate; everything is edge driven
// - after reset data in and out share the bidirectional line
// - data line driven only while returning read data
// - config bit 7 high enables dedicated output, four-wire mode
// - slave only, half duplex, never starts a transfer
// - dedicated output driven even when deselected in four-wire mode
// - header capture starts at first rising clock after select falls
// - msb first by default, lsb first when config bit 6 set
// - address increments when msb first, decrements when lsb first
// - header: read flag, two count bits, 13-bit start address
// - count bits 00,01,10 give one to three bytes, 11 four or more
// - data bytes follow header while select low and clock runs
// - up to three bytes, select may pause at any byte boundary
// - four or more bytes, late deselect resets and ends the transfer
// - soft reset bit restores all registers except power mode
// - burst of four or more ends at the burst end address
module acs_serial_port (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic CE_IN,
	input wire logic SELECT_N_IN,
	input wire logic SCLK_IN,
	input wire logic SDIO_IN,
	output logic SDIO_OUT,
	output logic SDIO_OE_OUT,
	output logic DEDICATED_SERIAL_OUT_OUT,
	output logic CFG_LSB_FIRST_OUT,
	output logic CFG_FOUR_WIRE_OUT,
	output logic [7:0] BURST_END_OUT,
	output logic WR_STROBE_OUT,
	output logic [7:0] WR_ADDR_OUT,
	output logic [7:0] WR_DATA_OUT
);
	import acs_pkg::*;
	`include "acs_regs.svh"

	acs_core_t r_reg;
	acs_core_t r_next;
	acs_mem_if mif ();

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// one bit into a byte in the selected order
	function automatic logic [7:0] acs_shift8(input logic [7:0] v, input logic d,
		input logic lsb);
		return lsb ? {d, v[7:1]} : {v[6:0], d};
	endfunction

	// next burst address, up or down with the bit order
	function automatic logic [12:0] acs_step(input logic [12:0] a, input logic lsb);
		return lsb ? a - 13'h0001 : a + 13'h0001;
	endfunction

	logic sclk_rise;
	logic sclk_fall;
	logic sel_rise;
	logic selected;
	logic lsb_first;
	logic four_wire;
	logic [15:0] hdr_new;
	logic [7:0] byte_new;
	logic [7:0] rd_byte;

	// -----------------------------------------------------------------
	// edge finding on synchronised pins
	// -----------------------------------------------------------------
	// only the second and third stages are looked at; the first is for settling
	assign sclk_rise = r_reg.sclk_s2 & ~r_reg.sclk_s3;
	assign sclk_fall = ~r_reg.sclk_s2 & r_reg.sclk_s3;
	assign sel_rise = r_reg.sel_s2 & ~r_reg.sel_s3;
	assign selected = ~r_reg.sel_s2;
	assign lsb_first = r_reg.cfg[`ACS_CFG_LSB_FIRST_BIT];
	assign four_wire = r_reg.cfg[`ACS_CFG_FOUR_WIRE_BIT];
	assign byte_new = acs_shift8(r_reg.shift, r_reg.dat_s2, lsb_first);
	assign hdr_new = lsb_first ? {r_reg.dat_s2, r_reg.hdr[15:1]} : {r_reg.hdr[14:0], r_reg.dat_s2};

	// -----------------------------------------------------------------
	// read byte source
	// -----------------------------------------------------------------
	// port registers live here because they steer the core; the rest is memory
	always_comb begin
		if (r_reg.addr[7:0] == `ACS_ADDR_PORT_CFG) begin
			rd_byte = r_reg.cfg;
		end else if (r_reg.addr[7:0] == `ACS_ADDR_BURST_END) begin
			rd_byte = r_reg.burst_end;
		end else begin
			rd_byte = mif.rd_data;
		end
	end

	// -----------------------------------------------------------------
	// protocol engine
	// -----------------------------------------------------------------
	// every step waits on a pin edge, so any slow clock works
	always_comb begin
		r_next = r_reg;
		r_next.sclk_s1 = SCLK_IN;
		r_next.sclk_s2 = r_reg.sclk_s1;
		r_next.sclk_s3 = r_reg.sclk_s2;
		r_next.sel_s1 = SELECT_N_IN;
		r_next.sel_s2 = r_reg.sel_s1;
		r_next.sel_s3 = r_reg.sel_s2;
		r_next.dat_s1 = SDIO_IN;
		r_next.dat_s2 = r_reg.dat_s1;
		r_next.wr_en = 1'b0;
		r_next.mem_clear = 1'b0;

		// soft reset lands on cfg and burst_end one cycle after the write that asked for it, on memory one cycle later
		if (r_reg.soft_rst) begin
			r_next.cfg = `ACS_CFG_RST;
			r_next.burst_end = `ACS_BURST_END_RST;
			r_next.mem_clear = 1'b1;
			r_next.soft_rst = 1'b0;
		end

		if (sel_rise) begin
			// a stall is harmless until the first data byte of a long burst is complete
			if (r_reg.st == ACS_ST_DONE ||
				(r_reg.st == ACS_ST_DATA && r_reg.cnt == `ACS_CNT_FOUR_PLUS &&
				r_reg.nbytes != 3'h0)) begin
				r_next.st = ACS_ST_HDR;
				r_next.bit_cnt = 4'h0;
			end
		end else if (selected && sclk_rise) begin
			// header capture begins on the first rising edge while selected
			case (r_reg.st)
				ACS_ST_HDR: begin
					r_next.hdr = hdr_new;
					r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
					if (r_reg.bit_cnt == `ACS_HDR_BITS) begin
						r_next.rd = hdr_new[15];
						r_next.cnt = hdr_new[14:13];
						r_next.addr = hdr_new[12:0];
						r_next.nbytes = 3'h0;
						r_next.bit_cnt = 4'h0;
						r_next.st = ACS_ST_DATA;
					end
				end
				ACS_ST_DATA: begin
					r_next.shift = byte_new;
					r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
					if (r_reg.bit_cnt[2:0] == `ACS_BYTE_LAST) begin
						r_next.bit_cnt = 4'h0;
						if (!r_reg.rd) begin
							if (r_reg.addr[7:0] == `ACS_ADDR_PORT_CFG) begin
								r_next.cfg = byte_new;
								r_next.cfg[`ACS_CFG_SOFT_RESET_BIT] = 1'b0;
								r_next.soft_rst = byte_new[`ACS_CFG_SOFT_RESET_BIT];
							end else if (r_reg.addr[7:0] == `ACS_ADDR_BURST_END) begin
								r_next.burst_end = byte_new;
							end else begin
								r_next.wr_en = 1'b1;
							end
							r_next.wr_addr = r_reg.addr[7:0];
							r_next.wr_data = byte_new;
						end
						if (r_reg.nbytes != 3'h7) begin
							r_next.nbytes = r_reg.nbytes + 3'h1;
						end
						r_next.addr = acs_step(r_reg.addr, lsb_first);
						// short transfers stop on the counted byte, long ones at burst end
						if (r_reg.cnt != `ACS_CNT_FOUR_PLUS) begin
							if (r_reg.nbytes[1:0] == r_reg.cnt) begin
								r_next.st = ACS_ST_DONE;
							end
						end else if (r_reg.addr[7:0] == r_reg.burst_end) begin
							r_next.st = ACS_ST_DONE;
						end
					end
				end
				default: begin
					r_next.st = ACS_ST_DONE;
				end
			endcase
		end else if (selected && sclk_fall && r_reg.st == ACS_ST_DATA && r_reg.rd) begin
			// new read bit after the falling edge, stable for the next rise
			if (r_reg.bit_cnt[2:0] == 3'h0) begin
				r_next.sdio_o = lsb_first ? rd_byte[0] : rd_byte[7];
				// shift toward the end that is sent next, so tx keeps the following bit there
				r_next.tx = acs_shift8(rd_byte, 1'b0, lsb_first);
			end else begin
				r_next.sdio_o = lsb_first ? r_reg.tx[0] : r_reg.tx[7];
				r_next.tx = acs_shift8(r_reg.tx, 1'b0, lsb_first);
			end
		end

		// the shared line is driven only for read data; never in four-wire mode
		// fresh read flag: a write after a read must not drive the line for one cycle
		r_next.sdio_oe = selected && !four_wire && r_next.rd &&
			r_next.st == ACS_ST_DATA;
		// four-wire output runs even while deselected, so no bus sharing then
		r_next.dso = four_wire ? r_next.sdio_o : 1'b0;
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			r_reg <= '0;
			r_reg.sclk_s1 <= 1'b0;
			r_reg.sel_s1 <= 1'b1;
			r_reg.sel_s2 <= 1'b1;
			r_reg.sel_s3 <= 1'b1;
			r_reg.st <= ACS_ST_HDR;
			r_reg.cfg <= `ACS_CFG_RST;
			r_reg.burst_end <= `ACS_BURST_END_RST;
		end else if (CE_IN) begin
			r_reg <= r_next;
		end
	end

	// -----------------------------------------------------------------
	// register memory
	// -----------------------------------------------------------------
	assign mif.ce = CE_IN;
	assign mif.wr_en = r_reg.wr_en;
	assign mif.wr_addr = r_reg.wr_addr;
	assign mif.wr_data = r_reg.wr_data;
	assign mif.rd_addr = r_reg.addr[7:0];
	assign mif.clear = r_reg.mem_clear;

	acs_regmem u_mem (
		.clk(CLK_IN),
		.resetn(RESETN_IN),
		.bus(mif)
	);

	// -----------------------------------------------------------------
	// outputs, all from flip-flops
	// -----------------------------------------------------------------
	assign SDIO_OUT = r_reg.sdio_o;
	assign SDIO_OE_OUT = r_reg.sdio_oe;
	assign DEDICATED_SERIAL_OUT_OUT = r_reg.dso;
	assign CFG_LSB_FIRST_OUT = r_reg.cfg[`ACS_CFG_LSB_FIRST_BIT];
	assign CFG_FOUR_WIRE_OUT = r_reg.cfg[`ACS_CFG_FOUR_WIRE_BIT];
	assign BURST_END_OUT = r_reg.burst_end;
	assign WR_STROBE_OUT = r_reg.wr_en;
	assign WR_ADDR_OUT = r_reg.wr_addr;
	assign WR_DATA_OUT = r_reg.wr_data;
endmodule

// ### acs_regs.svh
// register offsets, field positions and reset values of the configuration serial port
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

`define ACS_ADDR_PORT_CFG 8'h00
`define ACS_ADDR_BURST_END 8'h02
`define ACS_ADDR_MODES 8'h25
`define ACS_CFG_FOUR_WIRE_BIT 7
`define ACS_CFG_LSB_FIRST_BIT 6
`define ACS_CFG_SOFT_RESET_BIT 5
`define ACS_CFG_RST 8'h00
`define ACS_BURST_END_RST 8'h00
`define ACS_MEM_RST 8'h00
`define ACS_CNT_FOUR_PLUS 2'h3
`define ACS_HDR_BITS 4'hF
`define ACS_BYTE_LAST 3'h7

`endif

// ### acs_pkg.sv
// types shared by the configuration serial port modules
package acs_pkg;

	// protocol phase of the serial port
	typedef enum logic [1:0] {
		ACS_ST_HDR = 2'b00,
		ACS_ST_DATA = 2'b01,
		ACS_ST_DONE = 2'b10
	} acs_state_t;

	// whole state of the serial port core
	typedef struct packed {
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_s3;
		logic sel_s1;
		logic sel_s2;
		logic sel_s3;
		logic dat_s1;
		logic dat_s2;
		acs_state_t st;
		logic [3:0] bit_cnt;
		logic [15:0] hdr;
		logic [7:0] shift;
		logic rd;
		logic [1:0] cnt;
		logic [12:0] addr;
		logic [2:0] nbytes;
		logic [7:0] tx;
		logic sdio_o;
		logic sdio_oe;
		logic dso;
		logic [7:0] cfg;
		logic [7:0] burst_end;
		logic soft_rst;
		logic mem_clear;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} acs_core_t;

	// whole state of the register memory
	typedef struct packed {
		logic [255:0][7:0] mem;
		logic [7:0] rd_data;
	} acs_mem_t;

endpackage

// ### acs_mem_if.sv
// connection between the serial port core and its register memory
`timescale 1ns/10ps
interface acs_mem_if;
	logic ce;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic clear;

	modport core (output ce, output wr_en, output wr_addr, output wr_data, output rd_addr,
		output clear, input rd_data);
	modport mem (input ce, input wr_en, input wr_addr, input wr_data, input rd_addr,
		input clear, output rd_data);
endinterface

// ### acs_regmem.sv
// register memory of the serial-accessible space, registered read data
`timescale 1ns/10ps
module acs_regmem (
	input wire logic clk,
	input wire logic resetn,
	acs_mem_if.mem bus
);
	import acs_pkg::*;
	`include "acs_regs.svh"

	acs_mem_t m_reg;
	acs_mem_t m_next;

	// -----------------------------------------------------------------
	// write, soft clear and read path
	// -----------------------------------------------------------------
	// soft clear spares the power mode byte, which only a hard reset restores
	always_comb begin
		m_next = m_reg;
		if (bus.clear) begin
			for (int i = 0; i < 256; i++) begin
				if (8'(i) != `ACS_ADDR_MODES) begin
					m_next.mem[i] = `ACS_MEM_RST;
				end
			end
		end else if (bus.wr_en) begin
			m_next.mem[bus.wr_addr] = bus.wr_data;
		end
		m_next.rd_data = m_reg.mem[bus.rd_addr];
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			m_reg <= '0;
		end else if (bus.ce) begin
			m_reg <= m_next;
		end
	end

	assign bus.rd_data = m_reg.rd_data;
endmodule

// ### acs_chk_asserts.sv
// assertion checker of the configuration serial port
`timescale 1ns/10ps
module acs_chk (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic SELECT_N_IN,
	input wire logic SCLK_IN,
	input wire logic SDIO_OUT,
	input wire logic SDIO_OE_OUT,
	input wire logic CFG_FOUR_WIRE_OUT,
	input wire logic WR_STROBE_OUT,
	input wire logic [7:0] WR_ADDR_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	// ----
	// line direction
	// ----
	property p_oe_fw; SDIO_OE_OUT |-> !CFG_FOUR_WIRE_OUT; endproperty
	a_oe_fw: assert property (p_oe_fw) else $error("oe in four wire");
	property p_oe_sel; $rose(SDIO_OE_OUT) |-> !SELECT_N_IN; endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("oe unselected");
	property p_oe_end; $rose(SELECT_N_IN) |-> ##8 !SDIO_OE_OUT; endproperty
	a_oe_end: assert property (p_oe_end) else $error("oe kept");
	// turn-round lands in the high half after the last header bit
	property p_oe_clk; $rose(SDIO_OE_OUT) |-> SCLK_IN; endproperty
	a_oe_clk: assert property (p_oe_clk) else $error("oe early");
	property p_bit_lo; SDIO_OE_OUT && $past(SDIO_OE_OUT) && $changed(SDIO_OUT)
		|-> !SCLK_IN; endproperty
	a_bit_lo: assert property (p_bit_lo) else $error("bit moved high");
	// ----
	// write strobes
	// ----
	property p_stb_one; WR_STROBE_OUT |=> !WR_STROBE_OUT; endproperty
	a_stb_one: assert property (p_stb_one) else $error("strobe long");
	property p_stb_dir; WR_STROBE_OUT |-> !SDIO_OE_OUT && SCLK_IN; endproperty
	a_stb_dir: assert property (p_stb_dir) else $error("strobe misplaced");
	property p_stb_adr; WR_STROBE_OUT |-> WR_ADDR_OUT != 8'h00 && WR_ADDR_OUT != 8'h02;
	endproperty
	a_stb_adr: assert property (p_stb_adr) else $error("strobe on port reg");
endmodule
bind acs_serial_port acs_chk u_chk (.*);

// ### acs_spi_master.sv
// serial master model driving the configuration port
`timescale 1ns/10ps
module acs_spi_master (
	input wire logic clk_in,
	input wire logic wire_in,
	input wire logic dso_in,
	output logic sel_n_out,
	output logic sclk_out,
	output logic dat_out
);
	logic [7:0] rb [8];
	logic four = 1'b0;
	// idle deselected with the clock low, so no false first edge
	initial begin
		sel_n_out = 1'b1;
		sclk_out = 1'b0;
		dat_out = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// memory addresses stand in for defined registers; no reserved value is sent
	// the only slave on this bus, so a read never meets a second driver
	// 80 ns per bit is fs/20, faster than the fs/32 ceiling
	task automatic cyc(input logic b, input logic drv, output logic s);
		dat_out <= drv ? b : ~dat_out; // released line must not keep its level
		wt(10);
		sclk_out <= 1'b1;
		s = four ? dso_in : wire_in;
		wt(10);
		sclk_out <= 1'b0;
	endtask
	// header then n bytes, pausing before the first st bytes
	task automatic xfer(input logic [15:0] h, input logic [7:0] d [8], input int n,
		input logic lsb, input int st);
		logic s;
		sel_n_out <= 1'b0;
		wt(4);
		for (int i = 0; i < 16; i++) cyc(h[lsb ? i : 15 - i], 1'b1, s);
		for (int k = 0; k < n; k++) begin
			if (k < st) begin
				sel_n_out <= 1'b1;
				wt(12);
				sel_n_out <= 1'b0;
				wt(4);
			end
			for (int i = 0; i < 8; i++) begin
				cyc(d[k][lsb ? i : 7 - i], !h[15], s);
				rb[k][lsb ? i : 7 - i] = s;
			end
		end
		wt(10);
		sel_n_out <= 1'b1;
		wt(12);
	endtask
endmodule

// ### acs_serial_port_tb.sv
// self-checking bench of the configuration serial port
`timescale 1ns/10ps
module acs_serial_port_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ord = 1'b0;
	logic oe_seen = 1'b0;
	logic sel_n, sclk, m_dat, s_o, s_oe, dso, lsb_o, fw_o, stb;
	logic [7:0] bend, wa, wdat;
	logic [7:0] wd [8];
	int miscompares = 0;
	int check_count = 0;
	int stb_n = 0;
	int n0;
	// clock, strobe count and line-turn watch
	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (stb) stb_n <= stb_n + 1;
		if (s_oe) oe_seen <= 1'b1;
	end
	acs_serial_port dut (.CLK_IN(clk), .RESETN_IN(rstn), .CE_IN(1'b1), .SELECT_N_IN(sel_n),
		.SCLK_IN(sclk), .SDIO_IN(s_oe ? s_o : m_dat), .SDIO_OUT(s_o), .SDIO_OE_OUT(s_oe),
		.DEDICATED_SERIAL_OUT_OUT(dso), .CFG_LSB_FIRST_OUT(lsb_o), .CFG_FOUR_WIRE_OUT(fw_o),
		.BURST_END_OUT(bend), .WR_STROBE_OUT(stb), .WR_ADDR_OUT(wa), .WR_DATA_OUT(wdat));
	acs_spi_master m (.clk_in(clk), .wire_in(s_oe ? s_o : m_dat), .dso_in(dso),
		.sel_n_out(sel_n), .sclk_out(sclk), .dat_out(m_dat));
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xf(input logic rw, input logic [1:0] c, input logic [7:0] a, input int n,
		input int st);
		m.xfer({rw, c, 5'h00, a}, wd, n, ord, st);
	endtask
	task automatic close_out();
		$display("mismatches %0d checks %0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one byte out and back
	task automatic s_one();
		cmp("cfg", 8'h00, {6'h00, fw_o, lsb_o});
		wd[0] = 8'h5A;
		n0 = stb_n;
		xf(1'b0, 2'h0, 8'h10, 1, 0);
		cmp("strobes", 8'h01, 8'(stb_n - n0));
		cmp("wr addr", 8'h10, wa);
		cmp("wr data", 8'h5A, wdat);
		xf(1'b1, 2'h0, 8'h10, 1, 0);
		cmp("rd", 8'h5A, m.rb[0]);
	endtask
	// each short count, the writes pausing at every byte boundary
	task automatic s_counts();
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 3; k++) wd[k] = 8'(8'h31 + 16 * c + k);
			n0 = stb_n;
			xf(1'b0, 2'(c), 8'(8'h40 + 8 * c), c + 1, c + 1);
			cmp("strobes", 8'(c + 1), 8'(stb_n - n0));
			xf(1'b1, 2'(c), 8'(8'h40 + 8 * c), c + 1, 0);
			for (int k = 0; k <= c; k++) cmp("rd", wd[k], m.rb[k]);
		end
	endtask
	// open burst stops at its end; late deselect ends it
	task automatic s_burst();
		wd[0] = 8'h53;
		xf(1'b0, 2'h0, 8'h02, 1, 0);
		cmp("burst end", 8'h53, bend);
		for (int k = 0; k < 5; k++) wd[k] = 8'(8'hA0 + k);
		n0 = stb_n;
		xf(1'b0, 2'h3, 8'h50, 5, 1);
		cmp("strobes", 8'h04, 8'(stb_n - n0));
		cmp("wr addr", 8'h53, wa);
		wd[0] = 8'h77;
		n0 = stb_n;
		xf(1'b0, 2'h3, 8'h60, 1, 0);
		xf(1'b0, 2'h0, 8'h70, 1, 0);
		cmp("strobes", 8'h02, 8'(stb_n - n0));
		cmp("wr addr", 8'h70, wa);
	endtask
	// four-wire read leaves the shared line alone
	task automatic s_four();
		wd[0] = 8'h80;
		xf(1'b0, 2'h0, 8'h00, 1, 0);
		cmp("four wire", 8'h01, {7'h00, fw_o});
		m.four = 1'b1;
		oe_seen <= 1'b0;
		xf(1'b1, 2'h0, 8'h10, 1, 0);
		cmp("rd", 8'h5A, m.rb[0]);
		cmp("oe seen", 8'h00, {7'h00, oe_seen});
		wd[0] = 8'h00;
		xf(1'b0, 2'h0, 8'h00, 1, 0);
		m.four = 1'b0;
	endtask
	// reversed order counts down
	task automatic s_lsb();
		wd[0] = 8'h40;
		xf(1'b0, 2'h0, 8'h00, 1, 0);
		ord = 1'b1;
		cmp("lsb first", 8'h01, {7'h00, lsb_o});
		wd[0] = 8'hC1;
		wd[1] = 8'h2C;
		xf(1'b0, 2'h1, 8'h35, 2, 0);
		cmp("wr addr", 8'h34, wa);
		cmp("wr data", 8'h2C, wdat);
		xf(1'b1, 2'h1, 8'h35, 2, 0);
		cmp("rd", 8'hC1, m.rb[0]);
		wd[0] = 8'h00;
		xf(1'b0, 2'h0, 8'h00, 1, 0);
		ord = 1'b0;
	endtask
	// soft reset spares the power mode register
	task automatic s_soft();
		wd[0] = 8'h05;
		xf(1'b0, 2'h0, 8'h25, 1, 0);
		wd[0] = 8'h20;
		xf(1'b0, 2'h0, 8'h00, 1, 0);
		cmp("burst end", 8'h00, bend);
		xf(1'b1, 2'h0, 8'h10, 1, 0);
		cmp("rd", 8'h00, m.rb[0]);
		xf(1'b1, 2'h0, 8'h25, 1, 0);
		cmp("rd", 8'h05, m.rb[0]);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		s_one();
		s_counts();
		s_burst();
		s_four();
		s_lsb();
		s_soft();
		close_out();
	end
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		close_out();
	end
endmodule
